// [rtl/sleep_wake_pkg.sv]
// Constants and types for the sleep/wake controller
// Functional notes
// - Low-power state is entered only by the core's sleep instruction.
// - Sleep entry clears watchdog; it keeps counting if enabled in sleep.
// - Sleep entry clears power-down flag and sets watchdog-expiry flag.
// - Core clock is stopped while asleep.
// - Low-frequency internal oscillator keeps running while asleep.
// - Secondary timer oscillator keeps running while asleep.
// - Converter keeps running asleep when its dedicated RC clock is chosen.
// - I/O ports hold their pre-sleep drive state while asleep.
// - Sleep does not alter reset sources other than the watchdog.
// - Watchdog expiry in sleep wakes and resumes, clearing the watchdog-expiry flag.
// - Wake on pin, brown-out, power-on, watchdog or enabled interrupt.
// - Pin, brown-out, power-on reset the device; others resume execution.
// - Sleep prefetches the instruction at program counter plus one.
// - Interrupt wakes only if enabled, regardless of global enable.
// - Global enable clear continues inline; set runs next, then handler.
// - With global enable set the core branches to handler address 0004h.
// - Watchdog is cleared on every exit from sleep.
// - Enabled flag pending at sleep makes sleep a no-op; only the prefetch address changes.
// - Flag set during sleep: finish, wake, clear watchdog, update flags.
// - Crystal modes wait 1024 oscillator periods before resuming after wake.
// - Flags: compare4 bit5, compare3 bit4, timer6 bit3, timer4 bit1.
// - Unimplemented flag and enable bits always read zero.
package sleep_wake_pkg;
	localparam logic [11:0] ADDR_PERIPHERAL_IRQ_FLAGS_THREE    = 12'h000;
	localparam logic [11:0] ADDR_PIE3    = 12'h004;
	localparam logic [11:0] ADDR_INTERRUPT_CONTROL  = 12'h008;
	localparam logic [11:0] ADDR_STATUS  = 12'h00C;
	localparam logic [11:0] ADDR_WDTCTL  = 12'h010;
	localparam logic [11:0] ADDR_SLPCFG  = 12'h014;
	localparam logic [11:0] ADDR_SLPSTAT = 12'h018;
	localparam logic [7:0] PERIPHERAL_IRQ_FLAGS_THREE_MASK     = 8'h3A;
	localparam logic [7:0] PERIPHERAL_IRQ_FLAGS_THREE_RESET    = 8'h00;
	localparam logic [7:0] INTERRUPT_CONTROL_RESET  = 8'h00;
	localparam logic [7:0] WDTCTL_MASK   = 8'h3F;
	localparam logic [7:0] WDTCTL_RESET  = 8'h16;
	localparam int GIE_BIT    = 7;
	localparam int PEIE_BIT   = 6;
	localparam int EXPIRY_BIT = 4;
	localparam int PDOWN_BIT  = 3;
	localparam int SWDTEN_BIT = 0;
	localparam logic [15:0] HANDLER_ADDR = 16'h0004;
	localparam int OST_PERIODS = 1024;
	localparam logic [10:0] OST_COUNT = 11'h400;
	localparam logic [1:0] WDTE_ON     = 2'h3;
	localparam logic [1:0] WDTE_NSLEEP = 2'h2;
	localparam logic [1:0] WDTE_SW     = 2'h1;
	localparam logic [1:0] OSC_XT = 2'h1;
	localparam logic [1:0] OSC_HS = 2'h2;
	localparam logic [1:0] OSC_LP = 2'h3;
	typedef enum logic [3:0] {
		ST_RUN   = 4'h1,
		ST_SLEEP = 4'h2,
		ST_OST   = 4'h4,
		ST_RESUME = 4'h8
	} power_state_t;
endpackage

// [rtl/wdt_link_if.sv]
// Watchdog control and expiry signals between controller and timer
`timescale 1ns/1ns
interface wdt_link_if;
	logic        clear;
	logic        run;
	logic [4:0]  period_sel;
	logic        expired;
	modport ctrl  (output clear, output run, output period_sel, input expired);
	modport timer (input clear, input run, input period_sel, output expired);
endinterface

// [rtl/watchdog_counter.sv]
// Watchdog counter ticked by the low-frequency oscillator tick
`timescale 1ns/1ns
module watchdog_counter (
	input  wire logic  clk_sys,
	input  wire logic  resetn,
	input  wire logic  lfosc_tick,
	wdt_link_if.timer  wdt
);
	logic [31:0] count_ff;
	logic        expired_ff;
	logic [31:0] limit;

	// Prescale 5 bits select 2^(sel+5) ticks
	assign limit = 32'h1 << (6'(wdt.period_sel) + 6'h05);
	assign wdt.expired = expired_ff;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			count_ff <= 32'h0;
		end else if (wdt.clear || !wdt.run) begin
			count_ff <= 32'h0;
		end else if (lfosc_tick) begin
			count_ff <= (count_ff + 32'h1 >= limit) ? 32'h0 : count_ff + 32'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			expired_ff <= 1'b0;
		end else begin
			expired_ff <= wdt.run && !wdt.clear && lfosc_tick &&
				(count_ff + 32'h1 >= limit);
		end
	end
endmodule

// [rtl/sleep_wake_control.sv]
// Sleep entry, wake decision and register file over APB
`timescale 1ns/1ns
module sleep_wake_control (
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic         sleep_exec,
	input  wire logic         clrwdt_exec,
	input  wire logic [15:0]  program_counter,
	input  wire logic         lfosc_tick,
	input  wire logic [1:0]   wdt_enable_cfg,
	input  wire logic [1:0]   osc_mode,
	input  wire logic         external_irq_wake,
	input  wire logic         compare4_event,
	input  wire logic         compare3_event,
	input  wire logic         timer6_match_event,
	input  wire logic         timer4_match_event,
	input  wire logic         adc_rc_clock_sel,
	input  wire logic [7:0]   port_out_in,
	input  wire logic [7:0]   port_oe_in,
	output logic              cpu_clk_en,
	output logic              device_reset_req,
	output logic              resume_pulse,
	output logic              vector_req,
	output logic [15:0]       vector_addr,
	output logic [15:0]       prefetch_addr,
	output logic              lfosc_run,
	output logic              timer_osc_run,
	output logic              adc_clk_run,
	output logic [7:0]        port_out,
	output logic [7:0]        port_oe,
	output logic              asleep
);
	import sleep_wake_pkg::*;

	power_state_t state_ff, nxt_state;
	logic [7:0]  peripheral_irq_flags_three_ff;
	logic [7:0]  pie3_ff;
	logic [7:0]  interrupt_control_ff;
	logic        powerdown_flag_ff;
	logic        watchdog_expiry_flag_ff;
	logic [7:0]  wdtctl_ff;
	logic [10:0] ost_ff;
	logic        pending_vector_ff;
	logic [7:0]  port_out_ff;
	logic [7:0]  port_oe_ff;
	logic [15:0] prefetch_ff;
	logic        resume_ff;
	logic        vector_ff;
	logic        rst_req_ff;
	logic [31:0] prdata_ff;
	logic        wdt_wake_ff;

	logic        irq_wake;
	logic        wr_en;
	logic        rd_en;
	logic        enter_sleep;
	logic        nop_sleep;
	logic        wake_now;
	logic        crystal_mode;
	logic        wdt_run;
	logic [7:0]  peripheral_irq_flags_three_set;
	logic [7:0]  peripheral_irq_flags_three_wdata;
	logic        ext_reset_wake;
	wdt_link_if  wdt ();

	function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
		return a == b;
	endfunction

	assign ext_reset_wake = 1'b0;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = prdata_ff;

	// Event inputs into flag positions
	assign peripheral_irq_flags_three_set = {2'b00, compare4_event, compare3_event,
		timer6_match_event, 1'b0, timer4_match_event, 1'b0};

	// Peripheral enable gate also needs the peripheral master enable
	assign irq_wake = external_irq_wake ||
		(interrupt_control_ff[PEIE_BIT] && |(peripheral_irq_flags_three_ff & pie3_ff));

	assign crystal_mode = (osc_mode == OSC_XT) || (osc_mode == OSC_HS) ||
		(osc_mode == OSC_LP);
	assign enter_sleep = sleep_exec && (state_ff == ST_RUN) &&
		!irq_wake;
	assign nop_sleep = sleep_exec && (state_ff == ST_RUN) && irq_wake;
	assign wake_now = irq_wake || wdt.expired;

	always_comb begin
		case (wdt_enable_cfg)
			WDTE_ON:     wdt_run = 1'b1;
			WDTE_NSLEEP: wdt_run = (state_ff == ST_RUN);
			WDTE_SW:     wdt_run = wdtctl_ff[SWDTEN_BIT];
			default:     wdt_run = 1'b0;
		endcase
	end

	// Watchdog held clear through start-up, cleared on entry and exit
	assign wdt.run = wdt_run;
	assign wdt.period_sel = wdtctl_ff[5:1];
	assign wdt.clear = clrwdt_exec || enter_sleep || (state_ff == ST_OST) ||
		(state_ff == ST_SLEEP && wake_now);

	watchdog_counter u_wdt (
		.clk_sys    (clk_sys),
		.resetn     (resetn),
		.lfosc_tick (lfosc_tick),
		.wdt        (wdt)
	);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RUN: begin
				if (enter_sleep) begin
					nxt_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wake_now) begin
					nxt_state = crystal_mode ? ST_OST : ST_RESUME;
				end
			end
			ST_OST: begin
				if (ost_ff == 11'h001) begin
					nxt_state = ST_RESUME;
				end
			end
			ST_RESUME: nxt_state = ST_RUN;
			default:   nxt_state = ST_RUN;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ST_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Start-up counter counts clk_sys oscillator periods while the core clock is stopped
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ost_ff <= 11'h0;
		end else if (state_ff == ST_SLEEP && wake_now) begin
			ost_ff <= OST_COUNT;
		end else if (state_ff == ST_OST) begin
			ost_ff <= ost_ff - 11'h001;
		end
	end

	// Clock gate only reopens from a registered state
	assign cpu_clk_en = (state_ff == ST_RUN) ||
		(state_ff == ST_RESUME);
	assign asleep = (state_ff == ST_SLEEP) || (state_ff == ST_OST);
	assign lfosc_run = 1'b1;
	assign timer_osc_run = 1'b1;
	assign adc_clk_run = !asleep || adc_rc_clock_sel;

	// Pins frozen from the sleep edge until resume
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			port_out_ff <= 8'h00;
			port_oe_ff <= 8'h00;
		end else if (!asleep && !enter_sleep) begin
			port_out_ff <= port_out_in;
			port_oe_ff <= port_oe_in;
		end
	end
	assign port_out = port_out_ff;
	assign port_oe = port_oe_ff;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prefetch_ff <= 16'h0;
		end else if (sleep_exec) begin
			prefetch_ff <= program_counter + 16'h0001;
		end
	end
	assign prefetch_addr = prefetch_ff;

	// Watchdog expiry in run mode resets; in sleep it only wakes
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_req_ff <= 1'b0;
		end else begin
			rst_req_ff <= (wdt.expired && state_ff == ST_RUN) ||
				ext_reset_wake;
		end
	end
	assign device_reset_req = rst_req_ff;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wdt_wake_ff <= 1'b0;
		end else if (state_ff == ST_SLEEP && wake_now) begin
			wdt_wake_ff <= wdt.expired && !irq_wake;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pending_vector_ff <= 1'b0;
			resume_ff <= 1'b0;
			vector_ff <= 1'b0;
		end else begin
			resume_ff <= (state_ff == ST_RESUME);
			if (state_ff == ST_RESUME) begin
				pending_vector_ff <= interrupt_control_ff[GIE_BIT] && !wdt_wake_ff;
			end else if (pending_vector_ff && resume_ff) begin
				pending_vector_ff <= 1'b0;
			end
			// Vector after the in-line instruction has run
			vector_ff <= pending_vector_ff && resume_ff;
		end
	end
	assign resume_pulse = resume_ff;
	assign vector_req = vector_ff;
	assign vector_addr = HANDLER_ADDR;

	// Status flags: 1 after reset, set on clrwdt; updated on entry
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			powerdown_flag_ff <= 1'b1;
			watchdog_expiry_flag_ff <= 1'b1;
		end else if (enter_sleep) begin
			powerdown_flag_ff <= 1'b0;
			watchdog_expiry_flag_ff <= 1'b1;
		end else if (state_ff == ST_SLEEP && wdt.expired) begin
			watchdog_expiry_flag_ff <= 1'b0;
		end else if (clrwdt_exec && !nop_sleep) begin
			powerdown_flag_ff <= 1'b1;
			watchdog_expiry_flag_ff <= 1'b1;
		end
	end

	// Hardware set wins over a software clear in the same cycle
	assign peripheral_irq_flags_three_wdata = pwdata[7:0] & PERIPHERAL_IRQ_FLAGS_THREE_MASK;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			peripheral_irq_flags_three_ff <= PERIPHERAL_IRQ_FLAGS_THREE_RESET;
		end else if (wr_en && hit(paddr, ADDR_PERIPHERAL_IRQ_FLAGS_THREE)) begin
			peripheral_irq_flags_three_ff <= peripheral_irq_flags_three_wdata | peripheral_irq_flags_three_set;
		end else begin
			peripheral_irq_flags_three_ff <= peripheral_irq_flags_three_ff | peripheral_irq_flags_three_set;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pie3_ff <= 8'h00;
			interrupt_control_ff <= INTERRUPT_CONTROL_RESET;
			wdtctl_ff <= WDTCTL_RESET;
		end else if (wr_en) begin
			if (hit(paddr, ADDR_PIE3)) begin
				pie3_ff <= pwdata[7:0] & PERIPHERAL_IRQ_FLAGS_THREE_MASK;
			end
			if (hit(paddr, ADDR_INTERRUPT_CONTROL)) begin
				interrupt_control_ff <= pwdata[7:0];
			end
			if (hit(paddr, ADDR_WDTCTL)) begin
				wdtctl_ff <= pwdata[7:0] & WDTCTL_MASK;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prdata_ff <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				ADDR_PERIPHERAL_IRQ_FLAGS_THREE:   prdata_ff <= {24'h0, peripheral_irq_flags_three_ff};
				ADDR_PIE3:   prdata_ff <= {24'h0, pie3_ff};
				ADDR_INTERRUPT_CONTROL: prdata_ff <= {24'h0, interrupt_control_ff};
				ADDR_STATUS: prdata_ff <= {27'h0, watchdog_expiry_flag_ff,
					powerdown_flag_ff, 3'b000};
				ADDR_WDTCTL: prdata_ff <= {24'h0, wdtctl_ff};
				ADDR_SLPSTAT: prdata_ff <= {28'h0, state_ff};
				default:     prdata_ff <= 32'h0;
			endcase
		end
	end
endmodule

// [verif/core_model.sv]
// Core and peripheral stand-in: sleep instructions, flag events, slow tick
`timescale 1ns/1ns
module core_model (
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       go_sleep,
	input  wire logic [3:0] ev_req,
	output logic            sleep_exec,
	output logic [3:0]      ev_pulse,
	output logic            lfosc_tick
);
	logic [2:0] div_ff;
	// Slow oscillator as one tick in eight, keeps watchdog waits short
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sleep_exec <= 1'b0;
			ev_pulse   <= 4'h0;
			div_ff     <= 3'h0;
		end else begin
			sleep_exec <= go_sleep;
			ev_pulse   <= ev_req;
			div_ff     <= div_ff + 3'h1;
		end
	end
	assign lfosc_tick = div_ff == 3'h7;
endmodule

// [verif/sleep_wake_assertions.sv]
// Port checks for the sleep and wake controller
`timescale 1ns/1ns
module sleep_wake_assertions (
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        sleep_exec,
	input wire logic [15:0] program_counter,
	input wire logic        adc_rc_clock_sel,
	input wire logic [7:0]  port_out,
	input wire logic [7:0]  port_oe,
	input wire logic        cpu_clk_en,
	input wire logic        device_reset_req,
	input wire logic        resume_pulse,
	input wire logic        vector_req,
	input wire logic [15:0] vector_addr,
	input wire logic [15:0] prefetch_addr,
	input wire logic        lfosc_run,
	input wire logic        timer_osc_run,
	input wire logic        adc_clk_run,
	input wire logic        asleep
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	entry_cause_a: assert property (
		$rose(asleep) |-> $past(sleep_exec))
		else $error("sleep without instruction");
	gate_off_a: assert property (asleep |-> !cpu_clk_en)
		else $error("core clock runs asleep");
	gate_open_a: assert property ($rose(cpu_clk_en) |-> $past(asleep))
		else $error("clock reopened early");
	resume_seq_a: assert property (
		$rose(cpu_clk_en) |=> resume_pulse && !device_reset_req)
		else $error("wake not resumed");
	prefetch_a: assert property (
		sleep_exec && !asleep |=>
		prefetch_addr == $past(program_counter) + 16'h1)
		else $error("bad prefetch address");
	vector_a: assert property (
		vector_req |-> vector_addr == 16'h0004 && $past(resume_pulse))
		else $error("bad vector");
	port_hold_a: assert property (
		asleep && $past(asleep) |-> $stable(port_out) && $stable(port_oe))
		else $error("port moved asleep");
	osc_run_a: assert property (
		asleep |-> lfosc_run && timer_osc_run)
		else $error("oscillator stopped");
	adc_clk_a: assert property (
		asleep && adc_rc_clock_sel |-> adc_clk_run)
		else $error("converter clock stopped");
	no_reset_a: assert property (asleep |-> !device_reset_req)
		else $error("reset while asleep");
	cover property ($rose(asleep));
	cover property (vector_req);
	cover property ($rose(cpu_clk_en));
endmodule

bind sleep_wake_control sleep_wake_assertions chk_u (.clk_sys, .resetn,
	.sleep_exec, .program_counter, .adc_rc_clock_sel, .port_out, .port_oe,
	.cpu_clk_en, .device_reset_req, .resume_pulse, .vector_req,
	.vector_addr, .prefetch_addr, .lfosc_run, .timer_osc_run, .adc_clk_run,
	.asleep);

// [verif/sleep_wake_control_test.sv]
// Self-checking bench for the sleep and wake controller
`timescale 1ns/1ns
module sleep_wake_control_test;
	import sleep_wake_pkg::*;
	logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        sleep_exec, lfosc_tick, go_sleep, external_irq_wake;
	logic [1:0]  wdt_enable_cfg, osc_mode;
	logic [3:0]  ev_req, ev;
	logic [15:0] program_counter, vector_addr, prefetch_addr;
	logic [7:0]  port_out_in, port_oe_in, port_out, port_oe;
	logic        cpu_clk_en, device_reset_req, resume_pulse;
	logic        vector_req, asleep;
	int          n_errors = 0, num_checks = 0, cyc = 0, nvec = 0;

	sleep_wake_control dut (.clk_sys, .resetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_exec,
		.clrwdt_exec(1'b0), .program_counter, .lfosc_tick, .wdt_enable_cfg,
		.osc_mode, .external_irq_wake, .compare4_event(ev[3]),
		.compare3_event(ev[2]), .timer6_match_event(ev[1]),
		.timer4_match_event(ev[0]), .adc_rc_clock_sel(1'b1), .port_out_in,
		.port_oe_in, .cpu_clk_en, .device_reset_req, .resume_pulse,
		.vector_req, .vector_addr, .prefetch_addr, .lfosc_run(),
		.timer_osc_run(), .adc_clk_run(), .port_out, .port_oe, .asleep);
	core_model peer (.clk_sys, .resetn, .go_sleep, .ev_req, .sleep_exec,
		.ev_pulse(ev), .lfosc_tick);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) begin
		if (vector_req === 1'b1) nvec++;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop;
		end
	end

	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until pready seen high; the timeout bounds the wait
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic sleep_now(input logic exp);
		@(posedge clk_sys);
		go_sleep <= 1'b1;
		@(posedge clk_sys);
		go_sleep <= 1'b0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(32'(asleep), 32'(exp));
	endtask
	task automatic fire(input logic [3:0] e);
		@(posedge clk_sys);
		ev_req <= e;
		@(posedge clk_sys);
		ev_req <= 4'h0;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic wake_wait(input int lim, input int lo);
		int n;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (asleep !== 1'b0 && n < lim);
		chk(32'(n >= lo && n < lim), 32'h1);
	endtask

	task automatic t_regs;
		rd(ADDR_PERIPHERAL_IRQ_FLAGS_THREE, 32'h0);
		rd(ADDR_STATUS, 32'h18);
		rd(ADDR_WDTCTL, 32'h16);
		rd(ADDR_SLPCFG, 32'h0);
		apb(1'b1, ADDR_PERIPHERAL_IRQ_FLAGS_THREE, 32'hFF);
		rd(ADDR_PERIPHERAL_IRQ_FLAGS_THREE, 32'h3A);
		apb(1'b1, ADDR_PIE3, 32'hFF);
		rd(ADDR_PIE3, 32'h3A);
		apb(1'b1, ADDR_PIE3, 32'h0);
		apb(1'b1, ADDR_PERIPHERAL_IRQ_FLAGS_THREE, 32'h0);
	endtask
	task automatic t_flags;
		logic [7:0] pos [4] = '{8'h02, 8'h08, 8'h10, 8'h20};
		for (int i = 0; i < 4; i++) begin
			fire(4'(1 << i));
			rd(ADDR_PERIPHERAL_IRQ_FLAGS_THREE, {24'h0, pos[i]});
			apb(1'b1, ADDR_PERIPHERAL_IRQ_FLAGS_THREE, 32'h0);
		end
	endtask
	task automatic t_nop;
		apb(1'b1, ADDR_PIE3, 32'h20);
		apb(1'b1, ADDR_INTERRUPT_CONTROL, 32'h40);
		fire(4'h8);
		sleep_now(1'b0);
		rd(ADDR_STATUS, 32'h18);
		apb(1'b1, ADDR_PERIPHERAL_IRQ_FLAGS_THREE, 32'h0);
	endtask
	task automatic t_wake(input logic global_irq_enable);
		int v;
		logic [15:0] held;
		apb(1'b1, ADDR_INTERRUPT_CONTROL, {24'h0, global_irq_enable, 7'h40});
		program_counter <= 16'h1234;
		sleep_now(1'b1);
		chk(32'(cpu_clk_en), 32'h0);
		chk(32'(prefetch_addr), 32'h1235);
		rd(ADDR_STATUS, 32'h10);
		held = {port_oe_in, port_out_in};
		port_out_in <= ~port_out_in;
		port_oe_in <= ~port_oe_in;
		fire(4'h1);
		@(negedge clk_sys);
		chk(32'(asleep), 32'h1);
		chk(32'({port_oe, port_out}), 32'(held));
		v = nvec;
		fire(4'h8);
		wake_wait(20, 0);
		repeat (4) @(posedge clk_sys);
		chk(32'(nvec - v), 32'(global_irq_enable));
		rd(ADDR_STATUS, 32'h10);
		apb(1'b1, ADDR_PERIPHERAL_IRQ_FLAGS_THREE, 32'h0);
	endtask
	task automatic t_ost;
		osc_mode <= OSC_XT;
		sleep_now(1'b1);
		fire(4'h8);
		wake_wait(1100, 1015);
		apb(1'b1, ADDR_PERIPHERAL_IRQ_FLAGS_THREE, 32'h0);
		osc_mode <= 2'h0;
	endtask
	task automatic t_ext;
		sleep_now(1'b1);
		@(posedge clk_sys);
		external_irq_wake <= 1'b1;
		wake_wait(20, 0);
		@(posedge clk_sys);
		external_irq_wake <= 1'b0;
	endtask
	task automatic t_wdt;
		apb(1'b1, ADDR_WDTCTL, 32'h0);
		wdt_enable_cfg <= WDTE_ON;
		sleep_now(1'b1);
		wake_wait(400, 200);
		rd(ADDR_STATUS, 32'h0);
		wdt_enable_cfg <= 2'h0;
	endtask

	initial begin
		{psel, penable, pwrite, go_sleep, external_irq_wake} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		ev_req = 4'h0;
		wdt_enable_cfg = 2'h0;
		osc_mode = 2'h0;
		program_counter = 16'h0;
		port_out_in = 8'hA5;
		port_oe_in = 8'h3C;
		resetn = 1'b0;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		t_regs;
		t_flags;
		t_nop;
		t_wake(1'b0);
		t_wake(1'b1);
		t_ost;
		t_ext;
		t_wdt;
		report_and_stop;
	end
endmodule
